// ---- daq_port_cfg.svh ----
// constants of the acquisition card data port registers
// Contract
// (RL1) read of offset 4 returns result bits 7..0
// (RL2) read of offset 5 returns result 11..8, busy flag bit 4, zeros above
// (RL3) busy flag is one while result invalid, zero when ready
// (RL4) busy flag clears when a conversion finishes
// (RL5) write offset 4 loads channel one low byte; offset 5 loads high nibble
// (RL6) offsets 6 and 7 load channel two code, same layout
// (RL7) low byte is staged; output latch changes only on high-nibble write
// (RL8) high-nibble write moves nibble plus staged low byte into latch at once
// (RL9) host writes low byte before high nibble
// (RL10) each output latch drives its converter code
// (RL11) read offset 6 gives input lines 7..0, offset 7 lines 15..8
// (RL12) decode sixteen locations from switch-selected base only
// (RL13) reads and writes at one offset reach different registers
`ifndef DAQ_PORT_CFG_SVH
`define DAQ_PORT_CFG_SVH
`define OFS_ADC_LOW 4'h4
`define OFS_ADC_HIGH 4'h5
`define OFS_DAC_ONE_LOW 4'h4
`define OFS_DAC_ONE_HIGH 4'h5
`define OFS_DAC_TWO_LOW 4'h6
`define OFS_DAC_TWO_HIGH 4'h7
`define OFS_DIN_LOW 4'h6
`define OFS_DIN_HIGH 4'h7
`define BUSY_BIT 4
`define DAC_RESET 12'h000
`define STAGE_RESET 8'h00
`define RESULT_RESET 12'h000
`define BUSY_RESET 1'b0
`define RDATA_RESET 8'h00
`endif

// ---- daq_port_pkg.sv ----
// types of the acquisition card data port registers
package daq_port_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [11:0] code_type;
  typedef logic [15:0] din_type;
  typedef logic [3:0] offset_type;
  typedef logic [5:0] base_type;
endpackage : daq_port_pkg

// ---- dac_channel.sv ----
// one double-buffered output channel
`timescale 1ns/1ps
`include "daq_port_cfg.svh"
module dac_channel
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // write strobes
  input wire logic low_we,
  input wire logic high_we,
  input wire daq_port_pkg::byte_type wdata,
  // converter code
  output daq_port_pkg::code_type code
);
  import daq_port_pkg::*;
  byte_type stage_q;
  byte_type stage_d;
  code_type latch_q;
  code_type latch_d;

  always_comb
  begin
    stage_d = stage_q;
    latch_d = latch_q;
    if (low_we)
    begin
      stage_d = wdata; // RL7
    end
    if (high_we)
    begin
      latch_d = {wdata[3:0], stage_q}; // RL8
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage_q <= `STAGE_RESET;
      latch_q <= `DAC_RESET;
    end
    else
    begin
      stage_q <= stage_d;
      latch_q <= latch_d;
    end
  end

  assign code = latch_q; // RL10
endmodule : dac_channel

// ---- daq_data_port_registers.sv ----
// host data registers: converter result, output latches, input port
`timescale 1ns/1ps
`include "daq_port_cfg.svh"
module daq_data_port_registers
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // host io bus
  input wire logic [9:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire daq_port_pkg::byte_type io_wdata,
  output daq_port_pkg::byte_type io_rdata,
  output logic io_rvalid,
  // base switch
  input wire daq_port_pkg::base_type base_sel,
  // converter side
  input wire logic conv_start,
  input wire logic conv_done,
  input wire daq_port_pkg::code_type conv_result,
  // outputs and inputs
  output daq_port_pkg::code_type dac_one_code,
  output daq_port_pkg::code_type dac_two_code,
  input wire daq_port_pkg::din_type din_lines
);
  import daq_port_pkg::*;

  // ----------------------------
  // address decode
  // ----------------------------
  logic hit;
  offset_type ofs;
  logic rd_hit;
  logic wr_hit;
  // only the six upper address bits pick the card
  assign hit = (io_addr[9:4] == base_sel); // RL12
  assign ofs = io_addr[3:0];
  assign rd_hit = hit && io_rd; // RL12
  assign wr_hit = hit && io_wr; // RL12

  // ----------------------------
  // write strobes
  // ----------------------------
  logic one_low_we;
  logic one_high_we;
  logic two_low_we;
  logic two_high_we;

  // writes reach only the staging and latch side
  always_comb
  begin
    one_low_we = 1'b0;
    one_high_we = 1'b0;
    two_low_we = 1'b0;
    two_high_we = 1'b0;
    if (wr_hit)
    begin
      case (ofs)
        `OFS_DAC_ONE_LOW:
        begin
          one_low_we = 1'b1; // RL5 RL13
        end
        `OFS_DAC_ONE_HIGH:
        begin
          one_high_we = 1'b1; // RL5
        end
        `OFS_DAC_TWO_LOW:
        begin
          two_low_we = 1'b1; // RL6
        end
        `OFS_DAC_TWO_HIGH:
        begin
          two_high_we = 1'b1; // RL6
        end
        default:
        begin
          one_low_we = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------
  // conversion result
  // ----------------------------
  code_type result_q;
  code_type result_d;

  // result lines are only meaningful while done is high
  always_comb
  begin
    result_d = result_q;
    if (conv_done)
    begin
      result_d = conv_result; // RL4
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      result_q <= `RESULT_RESET;
    end
    else
    begin
      result_q <= result_d;
    end
  end

  // ----------------------------
  // busy flag
  // ----------------------------
  logic busy_q;
  logic busy_d;

  always_comb
  begin
    busy_d = busy_q;
    if (conv_done)
    begin
      busy_d = 1'b0; // RL4
    end
    // a start in the same cycle opens a new conversion, so it wins
    if (conv_start)
    begin
      busy_d = 1'b1; // RL3
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_q <= `BUSY_RESET;
    end
    else
    begin
      busy_q <= busy_d;
    end
  end

  // ----------------------------
  // read data
  // ----------------------------
  byte_type rdata_d;
  byte_type rdata_q;
  logic rvalid_d;
  logic rvalid_q;

  // reads reach only the result, the busy flag and the input port
  always_comb
  begin
    rdata_d = 8'h00;
    rvalid_d = rd_hit; // RL12
    if (rd_hit)
    begin
      case (ofs)
        `OFS_ADC_LOW:
        begin
          rdata_d = result_q[7:0]; // RL1 RL13
        end
        `OFS_ADC_HIGH:
        begin
          rdata_d = {4'h0, result_q[11:8]}; // RL2
          rdata_d[`BUSY_BIT] = busy_q; // RL2 RL3
        end
        `OFS_DIN_LOW:
        begin
          rdata_d = din_lines[7:0]; // RL11
        end
        `OFS_DIN_HIGH:
        begin
          rdata_d = din_lines[15:8]; // RL11
        end
        // other offsets in the window still answer, with zero
        default:
        begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q <= `RDATA_RESET;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign io_rdata = rdata_q;
  assign io_rvalid = rvalid_q;

  // ----------------------------
  // output channels
  // ----------------------------
  dac_channel u_one
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .low_we(one_low_we),
    .high_we(one_high_we),
    .wdata(io_wdata),
    .code(dac_one_code)
  );

  dac_channel u_two
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .low_we(two_low_we),
    .high_we(two_high_we),
    .wdata(io_wdata),
    .code(dac_two_code)
  );
endmodule : daq_data_port_registers

// ---- conv_model.sv ----
// converter model: answers a start pulse with a done pulse
`timescale 1ns/1ps
module conv_model #(parameter logic [3:0] LAT = 4'h5, parameter logic [11:0] VAL = 12'hA5C)
(
  input logic core_clk,
  input logic rstn,
  input logic conv_start,
  output logic conv_done,
  output logic [11:0] conv_result
);
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      cnt_q <= 4'h0;
      conv_done <= 1'b0;
    end
    else
    begin
      conv_done <= cnt_q == 4'h1;
      cnt_q <= conv_start ? LAT : (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
    end
  // outside done the result lines carry junk
  assign conv_result = conv_done ? VAL : ~VAL;
endmodule : conv_model

// ---- daq_props.sv ----
// assertions on the data port register pins
`timescale 1ns/1ps
module daq_props
(
  input logic core_clk,
  input logic rstn,
  input logic [9:0] io_addr,
  input logic io_rd,
  input logic io_wr,
  input logic [7:0] io_wdata,
  input logic [7:0] io_rdata,
  input logic io_rvalid,
  input logic [5:0] base_sel,
  input logic conv_start,
  input logic conv_done,
  input logic [11:0] conv_result,
  input logic [11:0] dac_one_code,
  input logic [11:0] dac_two_code,
  input logic [15:0] din_lines
);
  logic rh, wh, busy_q;
  logic [3:0] a;
  logic [11:0] res_q;
  logic [7:0] st_q;
  assign rh = io_rd && io_addr[9:4] == base_sel;
  assign wh = io_wr && io_addr[9:4] == base_sel;
  assign a = io_addr[3:0];
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      res_q <= 12'h000;
      busy_q <= 1'b0;
      st_q <= 8'h00;
    end
    else
    begin
      if (conv_done) res_q <= conv_result;
      busy_q <= conv_start || (busy_q && !conv_done);
      if (wh && a == 4'h4) st_q <= io_wdata;
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  rd_valid_a: assert property (io_rvalid == $past(rh)) else $error("bad valid");
  adc_low_a: assert property (rh && a == 4'h4 |=> io_rdata == $past(res_q[7:0])) else $error("bad low");
  adc_high_a: assert property (rh && a == 4'h5 |=>
    io_rdata == {3'b000, $past(busy_q), $past(res_q[11:8])}) else $error("bad high");
  din_read_a: assert property (rh && a[3:1] == 3'h3 |=>
    io_rdata == $past(a[0] ? din_lines[15:8] : din_lines[7:0])) else $error("bad din");
  one_hold_a: assert property (!(wh && a == 4'h5) |=> $stable(dac_one_code)) else $error("one moved");
  two_hold_a: assert property (!(wh && a == 4'h7) |=> $stable(dac_two_code)) else $error("two moved");
  one_commit_a: assert property (wh && a == 4'h5 |=>
    dac_one_code == {$past(io_wdata[3:0]), $past(st_q)}) else $error("bad commit");
  miss_quiet_a: assert property (!rh |=> !io_rvalid) else $error("miss answered");
  cover property (rh && a == 4'h5 && busy_q);
  cover property (wh && a == 4'h5);
  cover property (conv_done);
endmodule : daq_props
bind daq_data_port_registers daq_props u_props
(
  .core_clk(core_clk),
  .rstn(rstn),
  .io_addr(io_addr),
  .io_rd(io_rd),
  .io_wr(io_wr),
  .io_wdata(io_wdata),
  .io_rdata(io_rdata),
  .io_rvalid(io_rvalid),
  .base_sel(base_sel),
  .conv_start(conv_start),
  .conv_done(conv_done),
  .conv_result(conv_result),
  .dac_one_code(dac_one_code),
  .dac_two_code(dac_two_code),
  .din_lines(din_lines)
);

// ---- tb.sv ----
// self-checking bench for the data port registers
`timescale 1ns/1ps
module tb;
  logic core_clk = 0, rstn = 0, io_rd = 0, io_wr = 0, conv_start = 0, conv_done, io_rvalid;
  logic [9:0] io_addr = 10'h000;
  logic [7:0] io_wdata = 8'h00, io_rdata;
  logic [5:0] base_sel = 6'h22;
  logic [11:0] conv_result, dac_one_code, dac_two_code;
  logic [15:0] din_lines = 16'hC3A5;
  int miscompares = 0, tests_run = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  conv_model u_conv
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .conv_start(conv_start),
    .conv_done(conv_done),
    .conv_result(conv_result)
  );
  daq_data_port_registers DUT
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .io_addr(io_addr),
    .io_rd(io_rd),
    .io_wr(io_wr),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata),
    .io_rvalid(io_rvalid),
    .base_sel(base_sel),
    .conv_start(conv_start),
    .conv_done(conv_done),
    .conv_result(conv_result),
    .dac_one_code(dac_one_code),
    .dac_two_code(dac_two_code),
    .din_lines(din_lines)
  );
  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic cmp_flag(input string n, input logic e, input logic s);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask : cmp_flag
  task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask : cmp_byte
  task automatic cmp_code(input string n, input logic [11:0] e, input logic [11:0] s);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask : cmp_code
  task automatic acc(input logic w, input logic [9:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    io_addr <= ad;
    io_wdata <= d;
    io_wr <= w;
    io_rd <= !w;
    @(posedge core_clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1;
  endtask : acc
  task automatic rd(input logic [9:0] ad, input logic [7:0] e, input logic v);
    acc(1'b0, ad, 8'h00);
    cmp_flag("rvalid", v, io_rvalid);
    cmp_byte("rdata", e, io_rdata);
  endtask : rd
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      miscompares++;
      final_report;
    end
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    rd(10'h225, 8'h00, 1'b1);
    @(posedge core_clk);
    conv_start <= 1'b1;
    @(posedge core_clk);
    conv_start <= 1'b0;
    rd(10'h225, 8'h10, 1'b1);
    // next start lands on the very cycle the first conversion finishes
    repeat (3) @(posedge core_clk);
    conv_start <= 1'b1;
    @(posedge core_clk);
    conv_start <= 1'b0;
    rd(10'h225, 8'h1A, 1'b1);
    repeat (8) @(posedge core_clk);
    rd(10'h224, 8'h5C, 1'b1);
    rd(10'h225, 8'h0A, 1'b1);
    rd(10'h226, 8'hA5, 1'b1);
    rd(10'h227, 8'hC3, 1'b1);
    acc(1'b1, 10'h224, 8'h12);
    cmp_code("one", 12'h000, dac_one_code);
    acc(1'b1, 10'h225, 8'hF3);
    cmp_code("one", 12'h312, dac_one_code);
    acc(1'b1, 10'h226, 8'h9B);
    acc(1'b1, 10'h227, 8'h04);
    cmp_code("two", 12'h49B, dac_two_code);
    acc(1'b1, 10'h225, 8'h07);
    cmp_code("one", 12'h712, dac_one_code);
    acc(1'b1, 10'h215, 8'h01);
    cmp_code("one", 12'h712, dac_one_code);
    rd(10'h214, 8'h00, 1'b0);
    rd(10'h220, 8'h00, 1'b1);
    acc(1'b1, 10'h226, 8'h55);
    cmp_code("two", 12'h49B, dac_two_code);
    @(posedge core_clk);
    base_sel <= 6'h3F;
    rd(10'h3F6, 8'hA5, 1'b1);
    rd(10'h226, 8'h00, 1'b0);
    final_report;
  end
endmodule : tb
